// File: inc/pwmtb_pkg.sv
/*
 * Constants for the PWM master time base configuration block.
 * Assumes a single 100 MHz clock and a plain register port.
 */
// Overview of operation
// - Sync source code 000 selects routed input.
// - Trigger on every (postscale+1)th compare match.
// - Prescaler codes divide input clock 1 to 64.
// - Period register resets to 0xFFF8.
// - Divider register upper bits read zero.
// - Module enable bit runs the prescaler, counter, matches, sync and trigger.
// - External sync restarts counter only when enabled.
// - Compare match when counter equals compare value.
package pwmtb_pkg;
	// Register indices on the plain port.
	localparam logic [2:0]  ADDR_CONTROL   = 3'h0;
	localparam logic [2:0]  ADDR_DIVIDER   = 3'h1;
	localparam logic [2:0]  ADDR_PERIOD    = 3'h2;
	localparam logic [2:0]  ADDR_COMPARE   = 3'h3;
	localparam logic [2:0]  ADDR_COUNTER   = 3'h4;
	localparam logic [2:0]  ADDR_IRQ_STAT  = 3'h5;
	localparam logic [2:0]  ADDR_IRQ_MASK  = 3'h6;
	// Control register field positions.
	localparam int          BIT_ENABLE     = 15;
	localparam int          BIT_SYNC_EN    = 7;
	localparam int          SRC_LSB        = 4;
	localparam int          PS_LSB         = 0;
	// Field values and reset values.
	localparam logic [2:0]  SRC_ROUTED     = 3'h0;
	localparam logic [2:0]  DIV_RESERVED   = 3'h7;
	localparam logic [15:0] PERIOD_RESET   = 16'hfff8;
	localparam logic [15:0] ZERO16         = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'h80ff;
	// Interrupt status bit positions.
	localparam int          IRQ_TRIGGER    = 0;
	localparam int          IRQ_PERIOD     = 1;
	localparam int          IRQ_SYNC       = 2;
endpackage

// File: rtl/pwmtb_prescaler.sv
/*
 * Input clock prescaler producing a one-cycle tick.
 * Assumes the divide code is stable while running.
 */
`timescale 1ns/100ps
module pwmtb_prescaler import pwmtb_pkg::*; #(
	parameter int WIDTH = 6
) (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Control.
	input  wire logic       i_run,
	input  wire logic [2:0] i_div,
	// Tick out.
	output logic            o_tick
);
	logic [WIDTH-1:0] count;  // Free divider count.
	logic [WIDTH-1:0] limit;  // Terminal value for the code.

	// Limit is two to the code, minus one; reserved code behaves as divide-by-1.
	always_comb begin
		if (i_div == DIV_RESERVED) begin
			limit = '0;
		end else begin
			limit = WIDTH'((1 << i_div) - 1);
		end
	end

	// The count restarts while stopped so the first tick is a full period.
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !i_run) begin
			count <= '0;
		end else if (count >= limit) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	assign o_tick = i_run && (count >= limit);
endmodule

// File: rtl/pwmtb_postscaler.sv
/*
 * Postscaler for the special event trigger.
 * Assumes match pulses last one cycle.
 */
`timescale 1ns/100ps
module pwmtb_postscaler import pwmtb_pkg::*; (
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	// Control.
	input  wire logic       i_run,
	input  wire logic [3:0] i_ratio,
	input  wire logic       i_match,
	// Trigger out.
	output logic            o_trigger
);
	logic [3:0] seen;  // Matches seen since the last trigger.

	// Counts matches; it clears when disabled so a new run starts at zero.
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !i_run) begin
			seen <= '0;
		end else if (i_match) begin
			seen <= (seen == i_ratio) ? 4'h0 : seen + 4'h1;
		end
	end

	// The trigger is registered so it is a clean one-cycle pulse.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_trigger <= 1'b0;
		end else begin
			o_trigger <= i_run && i_match && (seen == i_ratio);
		end
	end
endmodule

// File: rtl/pwmtb_top.sv
/*
 * PWM primary master time base: registers, counter, sync and trigger.
 * Assumes the sync input is already routed and synchronous to i_clk.
 */
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module pwmtb_top import pwmtb_pkg::*; (
	// Clock and reset.
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Register port.
	input  wire logic [2:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [15:0]      o_rdata,
	// Sync input from peripheral pin routing.
	input  wire logic        i_external_sync_input,
	// Time base outputs.
	output logic [15:0]      o_master_time_base_counter,
	output logic             o_period_match,
	output logic             o_compare_match,
	output logic             o_event_trigger,
	output logic             o_irq
);
	logic [15:0] time_base_control;     // Enable, sync and postscale fields.
	logic [2:0]  input_clock_prescale;  // Divider code.
	logic [15:0] master_period_value;   // Period limit.
	logic [15:0] event_compare_value;   // Special event compare value.
	logic [2:0]  irq_status;            // Sticky event bits.
	logic [2:0]  irq_mask;              // Enables for the event bits.
	logic        tick;                  // Prescaled count strobe.
	logic        sync_valid;            // Accepted external sync.
	logic        sync_prev;             // Last sync level for edge finding.
	logic        module_enable_bit;
	logic        external_sync_enable;
	logic [2:0]  sync_source_select;
	logic [3:0]  event_trigger_postscale;

	assign module_enable_bit       = time_base_control[BIT_ENABLE];
	assign external_sync_enable    = time_base_control[BIT_SYNC_EN];
	assign sync_source_select      = time_base_control[SRC_LSB +: 3];
	assign event_trigger_postscale = time_base_control[PS_LSB +: 4];

	// Control register; unimplemented bits are never stored.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			time_base_control <= ZERO16;
		end else if (i_wr && i_addr == ADDR_CONTROL) begin
			time_base_control <= i_wdata & CTRL_WMASK;
		end
	end

	// Divider code; upper bits of the write are dropped.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			// Divide-by-1 is the reset default.
			input_clock_prescale <= '0;
		end else if (i_wr && i_addr == ADDR_DIVIDER) begin
			input_clock_prescale <= i_wdata[2:0];
		end
	end

	// Period and compare values; both take effect at once.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			master_period_value <= PERIOD_RESET;
			event_compare_value <= ZERO16;
		end else if (i_wr) begin
			if (i_addr == ADDR_PERIOD) begin
				master_period_value <= i_wdata;
			end
			if (i_addr == ADDR_COMPARE) begin
				event_compare_value <= i_wdata;
			end
		end
	end

	// Mask register.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			irq_mask <= 3'h0;
		end else if (i_wr && i_addr == ADDR_IRQ_MASK) begin
			irq_mask <= i_wdata[2:0];
		end
	end

	// Prescaler runs only while the module is enabled.
	pwmtb_prescaler #(.WIDTH(6)) u_prescaler (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_run    (module_enable_bit),
		.i_div    (input_clock_prescale),
		.o_tick   (tick)
	);

	// Edge detect on the sync level; only the routed source exists.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sync_prev <= 1'b0;
		end else begin
			sync_prev <= i_external_sync_input;
		end
	end

	// Reserved source codes select nothing, so no sync arrives.
	assign sync_valid = module_enable_bit && external_sync_enable
		&& (sync_source_select == SRC_ROUTED)
		&& i_external_sync_input && !sync_prev;

	// Master counter: a sync restarts it at once, otherwise it wraps after the period.
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !module_enable_bit) begin
			o_master_time_base_counter <= ZERO16;
		end else if (sync_valid) begin
			o_master_time_base_counter <= ZERO16;
		end else if (tick) begin
			if (o_master_time_base_counter >= master_period_value) begin
				o_master_time_base_counter <= ZERO16;
			end else begin
				o_master_time_base_counter <= o_master_time_base_counter + 16'h0001;
			end
		end
	end

	// Match strobes fire once, on the tick that leaves the matching count.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_period_match  <= 1'b0;
			o_compare_match <= 1'b0;
		end else begin
			o_period_match  <= module_enable_bit && tick
				&& (o_master_time_base_counter >= master_period_value);
			o_compare_match <= module_enable_bit && tick
				&& (o_master_time_base_counter == event_compare_value);
		end
	end

	pwmtb_postscaler u_postscaler (
		.i_clk     (i_clk),
		.i_resetn  (i_resetn),
		.i_run     (module_enable_bit),
		.i_ratio   (event_trigger_postscale),
		.i_match   (o_compare_match),
		.o_trigger (o_event_trigger)
	);

	// Sticky status; a new event wins over the clear by read.
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= ((i_rd && i_addr == ADDR_IRQ_STAT) ? 3'h0 : irq_status)
				| {sync_valid, o_period_match, o_event_trigger};
		end
	end

	assign o_irq = |(irq_status & irq_mask);

	// Read data one cycle after the strobe; unmapped addresses read zero.
	always_ff @(posedge i_clk) begin
		if (!i_resetn || !i_rd) begin
			o_rdata <= ZERO16;
		end else begin
			case (i_addr)
				ADDR_CONTROL:  o_rdata <= time_base_control;
				ADDR_DIVIDER:  o_rdata <= {13'h0000, input_clock_prescale};
				ADDR_PERIOD:   o_rdata <= master_period_value;
				ADDR_COMPARE:  o_rdata <= event_compare_value;
				ADDR_COUNTER:  o_rdata <= o_master_time_base_counter;
				ADDR_IRQ_STAT: o_rdata <= {13'h0000, irq_status};
				ADDR_IRQ_MASK: o_rdata <= {13'h0000, irq_mask};
				default:       o_rdata <= ZERO16;
			endcase
		end
	end

	// Assertions.
	a_period_reset: assert property (@(posedge i_clk) $rose(i_resetn) |-> master_period_value == PERIOD_RESET)
		else $error("period reset value wrong");
	a_div_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(i_rd && i_addr == ADDR_DIVIDER) |=> o_rdata[15:3] == 13'h0000)
		else $error("divider upper bits not zero");
	a_disabled_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!module_enable_bit |=> o_master_time_base_counter == ZERO16)
		else $error("counter moves while disabled");
	a_sync_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
		sync_valid |=> o_master_time_base_counter == ZERO16)
		else $error("sync did not restart counter");
	a_sync_gated: assert property (@(posedge i_clk) disable iff (!i_resetn)
		sync_valid |-> external_sync_enable && sync_source_select == SRC_ROUTED)
		else $error("sync accepted while off");
	a_no_reserved_sync: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(sync_source_select != SRC_ROUTED) |-> !sync_valid)
		else $error("reserved source gave sync");
	a_count_bound: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(module_enable_bit && tick && o_master_time_base_counter >= master_period_value && !sync_valid)
		|=> o_master_time_base_counter == ZERO16)
		else $error("counter did not wrap");
	a_compare_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_compare_match |-> $past(o_master_time_base_counter) == $past(event_compare_value))
		else $error("compare match without equality");
	a_trigger_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
		o_event_trigger |-> $past(o_compare_match))
		else $error("trigger without match");
	a_tick_div1: assert property (@(posedge i_clk) disable iff (!i_resetn)
		(module_enable_bit && input_clock_prescale == 3'h0) |-> tick)
		else $error("divide-by-1 missed tick");
	c_trigger: cover property (@(posedge i_clk) o_event_trigger);
	c_sync: cover property (@(posedge i_clk) sync_valid);
	c_period: cover property (@(posedge i_clk) o_period_match);
	c_irq: cover property (@(posedge i_clk) o_irq);
endmodule

// File: verification/pwmtb_sync_model.sv
/*
 * Model of the external sync source seen through the pin routing.
 * Assumes it shares the block clock, as the routed input is synchronous.
 */
`timescale 1ns/100ps
module pwmtb_sync_model (
	// Clock.
	input  wire logic       i_clk,
	// Control from the bench.
	input  wire logic       i_run,
	input  wire logic [7:0] i_gap,
	// Sync pulse out.
	output logic            o_sync
);
	logic [7:0] cnt; // Cycles since the last pulse.

	// A one-cycle pulse every i_gap+1 cycles; the line idles low when stopped.
	always_ff @(posedge i_clk) begin
		if (!i_run || cnt == i_gap) begin
			cnt <= 8'h00;
		end else begin
			cnt <= cnt + 8'h01;
		end
		o_sync <= i_run && cnt == i_gap;
	end
endmodule

// File: verification/pwmtb_tb_top.sv
/*
 * Self-checking bench for the master time base block.
 * Assumes the register map and timing described with the design.
 */
`timescale 1ns/100ps
module pwmtb_tb_top import pwmtb_pkg::*;;
	logic        i_clk, i_resetn, i_wr, i_rd, i_external_sync_input, sy_run;
	logic [2:0]  i_addr;
	logic [15:0] i_wdata, o_rdata, o_master_time_base_counter, rv;
	logic        o_period_match, o_compare_match, o_event_trigger, o_irq;
	int          error_cnt, check_count, cyc, n, m;

	pwmtb_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
		.i_rd(i_rd), .o_rdata(o_rdata), .i_external_sync_input(i_external_sync_input),
		.o_master_time_base_counter(o_master_time_base_counter), .o_period_match(o_period_match),
		.o_compare_match(o_compare_match), .o_event_trigger(o_event_trigger), .o_irq(o_irq));
	pwmtb_sync_model sync_src (.i_clk(i_clk), .i_run(sy_run), .i_gap(8'd49), .o_sync(i_external_sync_input));

	// Free-running clock; the timeout guards against a stuck handshake.
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 100000) begin
			error_cnt++;
			end_sim();
		end
	end

	// Compares on four-state values so unknowns never match.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample there.
	task automatic rd(input logic [2:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 rv = o_rdata;
	endtask
	// Cycles until the next pulse of a chosen output, bounded.
	task automatic wait_on(input int which, output int k);
		k = 0;
		do begin
			@(posedge i_clk);
			k++;
			if (o_compare_match === 1'b1) m++;
		end while (k < 20000 && (which ? o_event_trigger : o_period_match) !== 1'b1);
	endtask
	function automatic logic [15:0] ctl(input bit en, input bit se, input logic [2:0] s, input logic [3:0] p);
		return {en, 7'h00, se, s, p};
	endfunction
	task automatic end_sim();
		if (error_cnt == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		{i_wr, i_rd, i_addr, i_wdata, sy_run, error_cnt, check_count} = '0;
		i_resetn = 1'b0;
		void'($urandom(18574));
		repeat (4) @(posedge i_clk);
		i_resetn <= 1'b1;
		rd(ADDR_PERIOD); chk(rv, 16'hfff8);
		rd(ADDR_DIVIDER); chk(rv, 16'h0000);
		wr(ADDR_DIVIDER, 16'hffff);
		rd(ADDR_DIVIDER); chk(rv, 16'h0007);
		rd(3'h7); chk(rv, 16'h0000);
		// Each prescale code with a random short period; reserved code 7 runs undivided.
		for (int d = 0; d < 8; d++) begin
			n = 2 + $urandom % 8;
			wr(ADDR_CONTROL, 16'h0000);
			wr(ADDR_DIVIDER, 16'(d));
			wr(ADDR_PERIOD, 16'(n));
			wr(ADDR_CONTROL, ctl(1, 0, 3'h0, 4'h0));
			wait_on(0, m);
			wait_on(0, m);
			chk(16'(m), 16'((n + 1) << (d % 7)));
			// The counter went to zero at the same edge that raised the match.
			chk(o_master_time_base_counter, ZERO16);
		end
		wr(ADDR_CONTROL, 16'h0000);
		rd(ADDR_COUNTER); chk(rv, 16'h0000);
		// Every postscale code: matches per trigger.
		wr(ADDR_DIVIDER, 16'h0000);
		wr(ADDR_PERIOD, 16'h0003);
		wr(ADDR_COMPARE, 16'h0001);
		for (int p = 0; p < 16; p++) begin
			wr(ADDR_CONTROL, 16'h0000);
			wr(ADDR_CONTROL, ctl(1, 0, 3'h0, 4'(p)));
			wait_on(1, n);
			m = 0;
			wait_on(1, n);
			chk(16'(m), 16'(p + 1));
		end
		// Period above the sync gap so the sync restarts each cycle.
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_PERIOD, 16'h0100);
		sy_run <= 1'b1;
		for (int s = 0; s < 3; s++) begin
			wr(ADDR_CONTROL, 16'h0000);
			wr(ADDR_CONTROL, ctl(1, s != 1, 3'(s == 2), 4'h0));
			m = 0;
			wait_on(0, n);
			chk(16'(n >= 20000), 16'(s == 0));
		end
		sy_run <= 1'b0;
		// Interrupt: event while masked, then unmask, then read-clear.
		wr(ADDR_CONTROL, 16'h0000);
		wr(ADDR_PERIOD, 16'h0004);
		wr(ADDR_IRQ_MASK, 16'h0000);
		rd(ADDR_IRQ_STAT);
		wr(ADDR_CONTROL, ctl(1, 0, 3'h0, 4'h0));
		wait_on(0, n);
		wr(ADDR_CONTROL, 16'h0000);
		chk(16'(o_irq), 16'h0000);
		wr(ADDR_IRQ_MASK, 16'h0002);
		// The mask lands at this edge, so let it settle before looking.
		#1;
		chk(16'(o_irq), 16'h0001);
		// Compare value 1 lies below period 4, so the trigger bit is set as well.
		rd(ADDR_IRQ_STAT); chk(rv, 16'h0003);
		rd(ADDR_IRQ_STAT); chk(rv, 16'h0000);
		chk(16'(o_irq), 16'h0000);
		end_sim();
	end
endmodule
